// ===== include/dtc_consts.vh
// Constants for the D/A trigger, status and channel control block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// Trigger source codes
`define DTC_SRC_BUS       3'h0
`define DTC_SRC_HOLD      3'h1
`define DTC_SRC_EXT       3'h2
`define DTC_SRC_TTL       3'h3
`define DTC_SRC_IMM       3'h4

// Trigger state codes, one-hot
`define DTC_ST_IDLE       2'h1
`define DTC_ST_WAIT       2'h2

// Status byte summary positions
`define DTC_STB_QUES_BIT  3
`define DTC_STB_OPER_BIT  7

// Reset values
`define DTC_ENA_RST       16'h0000
`define DTC_SRC_RST       3'h1

// Output mode encoding
`define DTC_MODE_VOLT     1'b0
`define DTC_MODE_CURR     1'b1

// Relay state encoding
`define DTC_RELAY_OPEN    1'b0
`define DTC_RELAY_CLOSED  1'b1

// Self-test outcome codes
`define DTC_TST_PASS      16'h0000

`endif

// ===== src/dtc_top.v
// Trigger, status and channel control logic of a multichannel D/A module
//
// Behaviour
// - Per TTL line enable, driven on trigger
// - Relay state per channel, 0 open 1 closed
// - Immediate write updates output at once
// - Triggered write pending until trigger and relay
// - Triggered readback returns most recent write
// - Per channel current or voltage mode
// - Operation condition read is non-destructive
// - Status byte bit 7 from operation AND
// - Operation event read clears its bits
// - Preset zeroes enables, leaves condition, event
// - Questionable condition read is non-destructive
// - Status byte bit 3 from questionable AND
// - Questionable event read clears its bits
// - Both enable masks read back last value
// - Single or full self-test, 16-bit result
// - Module trigger source held and readable
// - Software trigger only for bus or hold
// - Abort forces idle, trigger system off
// - Initiate moves idle to wait-for-trigger
// - Common trigger gives immediate trigger event
// - Trigger status as a 16-bit word
`timescale 1ns/1ps
`include "dtc_consts.vh"

module dtc_top #(
    parameter NCH   = 16,
    parameter DW    = 16,
    parameter NTTL  = 8,
    parameter SW    = 16,
    parameter NTEST = 4
) (
    input  wire                 clk_sys,
    input  wire                 sys_rst,
    input  wire                 clk_en,
    // Channel commands
    input  wire [3:0]           ch_sel,
    input  wire                 imm_wr,
    input  wire                 trg_wr,
    input  wire [DW-1:0]        lvl_data,
    input  wire                 relay_wr,
    input  wire                 relay_val,
    input  wire                 mode_wr,
    input  wire                 mode_val,
    output reg  [DW-1:0]        trg_lvl_rd,
    output reg                  relay_rd,
    output reg                  mode_rd,
    output reg  [NCH*DW-1:0]    dac_out,
    output reg  [NCH-1:0]       relay_out,
    output reg  [NCH-1:0]       mode_out,
    // Trigger system
    input  wire [2:0]           src_sel,
    input  wire                 src_wr,
    output reg  [2:0]           src_rd,
    input  wire                 soft_trg,
    input  wire                 common_trg,
    input  wire                 ext_trg_pin,
    input  wire [NTTL-1:0]      ttl_in_pin,
    input  wire                 abort_cmd,
    input  wire                 init_cmd,
    input  wire [NTTL-1:0]      ttl_ena_wdata,
    input  wire                 ttl_ena_wr,
    output reg  [NTTL-1:0]      ttl_ena_rd,
    output reg  [NTTL-1:0]      ttl_out,
    output reg  [NTTL-1:0]      ttl_oe,
    output reg  [15:0]          trg_status,
    // Status groups
    input  wire [SW-1:0]        oper_cond_in,
    input  wire [SW-1:0]        ques_cond_in,
    input  wire                 oper_ena_wr,
    input  wire                 ques_ena_wr,
    input  wire [SW-1:0]        ena_wdata,
    input  wire                 stat_preset,
    input  wire                 oper_evt_rd,
    input  wire                 ques_evt_rd,
    output reg  [SW-1:0]        oper_cond_rd,
    output reg  [SW-1:0]        ques_cond_rd,
    output reg  [SW-1:0]        oper_evt_q,
    output reg  [SW-1:0]        ques_evt_q,
    output reg  [SW-1:0]        oper_ena_rd,
    output reg  [SW-1:0]        ques_ena_rd,
    output wire [7:0]           status_byte,
    // Self-test
    input  wire                 tst_start,
    input  wire                 tst_all,
    input  wire [3:0]           tst_num,
    output reg                  tst_done,
    output reg  [15:0]          tst_result
);

    localparam ST_IDLE = `DTC_ST_IDLE;
    localparam ST_WAIT = `DTC_ST_WAIT;
    localparam integer TST_LAST = NTEST - 1;

    reg [DW-1:0]   pend_r [0:NCH-1];
    reg [DW-1:0]   last_r [0:NCH-1];
    reg [1:0]      state_r;
    reg [1:0]      state_nxt;
    reg            ext_s1_r;
    reg            ext_s2_r;
    reg            ext_d_r;
    reg [NTTL-1:0] ttl_s1_r;
    reg [NTTL-1:0] ttl_s2_r;
    reg [NTTL-1:0] ttl_d_r;
    reg [NCH-1:0]  armed_r;
    reg [SW-1:0]   oper_prev_r;
    reg [SW-1:0]   ques_prev_r;
    reg            tst_busy_r;
    reg [3:0]      tst_idx_r;
    reg [3:0]      tst_last_r;
    reg [15:0]     tst_acc_r;
    integer        i;

    // Single test: number 0 checks the trigger state, 1 the source code, others pass
    function [15:0] dtc_test;
        input [3:0] num;
        input [1:0] st;
        input [2:0] src;
        begin
            case (num)
                4'h0: dtc_test = (st == ST_IDLE || st == ST_WAIT) ?
                                 `DTC_TST_PASS : 16'h0001;
                4'h1: dtc_test = (src <= `DTC_SRC_IMM) ?
                                 `DTC_TST_PASS : 16'h0002;
                default: dtc_test = `DTC_TST_PASS;
            endcase
        end
    endfunction

    // Trigger event decode; soft trigger ignored unless bus or hold
    wire soft_ok  = soft_trg &&
                    (src_rd == `DTC_SRC_BUS || src_rd == `DTC_SRC_HOLD);
    wire ext_edge = ext_s2_r & ~ext_d_r;
    wire ttl_edge = |(ttl_s2_r & ~ttl_d_r);
    wire src_evt  = (src_rd == `DTC_SRC_IMM) ||
                    (src_rd == `DTC_SRC_EXT && ext_edge) ||
                    (src_rd == `DTC_SRC_TTL && ttl_edge);
    wire trg_evt  = soft_ok || common_trg || src_evt;
    wire fire     = (state_r == ST_WAIT) && trg_evt && !abort_cmd;

    // Summary bits into the status byte
    assign status_byte = {|(oper_evt_q & oper_ena_rd), 3'h0,
                          |(ques_evt_q & ques_ena_rd), 3'h0};

    // Trigger state machine next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (init_cmd && !abort_cmd)
                    state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (abort_cmd)
                    state_nxt = ST_IDLE;
                else if (fire)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Pin synchronisers; second stage only feeds the edge logic
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_d_r  <= 1'b0;
            ttl_s1_r <= {NTTL{1'b0}};
            ttl_s2_r <= {NTTL{1'b0}};
            ttl_d_r  <= {NTTL{1'b0}};
        end else if (clk_en) begin
            ext_s1_r <= ext_trg_pin;
            ext_s2_r <= ext_s1_r;
            ext_d_r  <= ext_s2_r;
            ttl_s1_r <= ttl_in_pin;
            ttl_s2_r <= ttl_s1_r;
            ttl_d_r  <= ttl_s2_r;
        end
    end

    // Trigger state, source and TTL output enables
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r    <= ST_IDLE;
            src_rd     <= `DTC_SRC_RST;
            ttl_ena_rd <= {NTTL{1'b0}};
            ttl_out    <= {NTTL{1'b0}};
            ttl_oe     <= {NTTL{1'b0}};
        end else if (clk_en) begin
            state_r <= state_nxt;
            if (src_wr)
                src_rd <= src_sel;
            if (ttl_ena_wr)
                ttl_ena_rd <= ttl_ena_wdata;
            // One-cycle pulse on each enabled line when triggered
            ttl_out <= fire ? ttl_ena_rd : {NTTL{1'b0}};
            ttl_oe  <= fire ? ttl_ena_rd : {NTTL{1'b0}};
        end
    end

    // Trigger status word: state, source, armed channels present
    always @(posedge clk_sys) begin
        if (sys_rst)
            trg_status <= 16'h0000;
        else if (clk_en)
            trg_status <= {10'h000, |armed_r, src_rd,
                           state_r};
    end

    // Channel levels, relays and modes
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            relay_out <= {NCH{`DTC_RELAY_OPEN}};
            mode_out  <= {NCH{`DTC_MODE_VOLT}};
            armed_r   <= {NCH{1'b0}};
            dac_out   <= {NCH*DW{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                pend_r[i] <= {DW{1'b0}};
                last_r[i] <= {DW{1'b0}};
            end
        end else if (clk_en) begin
            if (relay_wr)
                relay_out[ch_sel] <= relay_val;
            if (mode_wr)
                mode_out[ch_sel] <= mode_val;
            // Apply armed values; relay must be closed to take effect
            if (fire) begin
                for (i = 0; i < NCH; i = i + 1) begin
                    if (armed_r[i] && relay_out[i]) begin
                        dac_out[i*DW +: DW] <= pend_r[i];
                        armed_r[i] <= 1'b0;
                    end
                end
            end
            // Immediate write goes out at once; relay gates terminals
            if (imm_wr) begin
                dac_out[ch_sel*DW +: DW] <= lvl_data;
                last_r[ch_sel] <= lvl_data;
            end
            // New pending value wins over an apply in the same cycle
            if (trg_wr) begin
                pend_r[ch_sel]  <= lvl_data;
                armed_r[ch_sel] <= 1'b1;
                last_r[ch_sel]  <= lvl_data;
            end
        end
    end

    // Registered readback of the selected channel
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            trg_lvl_rd <= {DW{1'b0}};
            relay_rd   <= 1'b0;
            mode_rd    <= 1'b0;
        end else if (clk_en) begin
            trg_lvl_rd <= last_r[ch_sel];
            relay_rd   <= relay_out[ch_sel];
            mode_rd    <= mode_out[ch_sel];
        end
    end

    // Status groups: rising condition bits latch into events
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            oper_cond_rd <= {SW{1'b0}};
            ques_cond_rd <= {SW{1'b0}};
            oper_prev_r  <= {SW{1'b0}};
            ques_prev_r  <= {SW{1'b0}};
            oper_evt_q   <= {SW{1'b0}};
            ques_evt_q   <= {SW{1'b0}};
            oper_ena_rd  <= `DTC_ENA_RST;
            ques_ena_rd  <= `DTC_ENA_RST;
        end else if (clk_en) begin
            // Condition copies are never touched by a read
            oper_cond_rd <= oper_cond_in;
            ques_cond_rd <= ques_cond_in;
            oper_prev_r  <= oper_cond_in;
            ques_prev_r  <= ques_cond_in;
            // Read clears, but a new rise in that cycle survives
            oper_evt_q <= (oper_evt_rd ? {SW{1'b0}} : oper_evt_q) |
                          (oper_cond_in & ~oper_prev_r);
            ques_evt_q <= (ques_evt_rd ? {SW{1'b0}} : ques_evt_q) |
                          (ques_cond_in & ~ques_prev_r);
            // Preset overrides a write in the same cycle
            if (stat_preset) begin
                oper_ena_rd <= `DTC_ENA_RST;
                ques_ena_rd <= `DTC_ENA_RST;
            end else begin
                if (oper_ena_wr)
                    oper_ena_rd <= ena_wdata;
                if (ques_ena_wr)
                    ques_ena_rd <= ena_wdata;
            end
        end
    end

    // Self-test sequencer: one test, or all in turn with OR of codes
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            tst_busy_r <= 1'b0;
            tst_idx_r  <= 4'h0;
            tst_last_r <= 4'h0;
            tst_acc_r  <= 16'h0000;
            tst_done   <= 1'b0;
            tst_result <= 16'h0000;
        end else if (clk_en) begin
            tst_done <= 1'b0;
            if (!tst_busy_r && tst_start) begin
                tst_busy_r <= 1'b1;
                tst_idx_r  <= tst_all ? 4'h0 : tst_num;
                tst_last_r <= tst_all ? TST_LAST[3:0] : tst_num;
                tst_acc_r  <= 16'h0000;
            end else if (tst_busy_r) begin
                if (tst_idx_r == tst_last_r) begin
                    tst_busy_r <= 1'b0;
                    tst_done   <= 1'b1;
                    tst_result <= tst_acc_r |
                        dtc_test(tst_idx_r, state_r, src_rd);
                end else begin
                    tst_acc_r <= tst_acc_r |
                        dtc_test(tst_idx_r, state_r, src_rd);
                    tst_idx_r <= tst_idx_r + 4'h1;
                end
            end
        end
    end

endmodule // dtc_top

// ===== verification/dtc_assertions.sv
// Concurrent checks on the status and trigger ports of the control block
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_checker #(parameter NTTL = 8, parameter SW = 16) (
    input wire            clk_sys,
    input wire            sys_rst,
    input wire            clk_en,
    input wire [SW-1:0]   oper_cond_in,
    input wire [SW-1:0]   ques_cond_in,
    input wire            oper_evt_rd,
    input wire            ques_evt_rd,
    input wire            oper_ena_wr,
    input wire            ques_ena_wr,
    input wire [SW-1:0]   ena_wdata,
    input wire            stat_preset,
    input wire [SW-1:0]   oper_evt_q,
    input wire [SW-1:0]   ques_evt_q,
    input wire [SW-1:0]   oper_ena_rd,
    input wire [SW-1:0]   ques_ena_rd,
    input wire [7:0]      status_byte,
    input wire [NTTL-1:0] ttl_ena_rd,
    input wire [NTTL-1:0] ttl_out,
    input wire [NTTL-1:0] ttl_oe
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Summary bits track event and mask in the same cycle
    a_oper_summary: assert property (
        status_byte[`DTC_STB_OPER_BIT] == |(oper_evt_q & oper_ena_rd))
        else $error("operation summary bit wrong");
    a_ques_summary: assert property (
        status_byte[`DTC_STB_QUES_BIT] == |(ques_evt_q & ques_ena_rd))
        else $error("questionable summary bit wrong");
    // A read with no new rise must leave nothing behind
    a_oper_clear: assert property (
        clk_en && oper_evt_rd && $stable(oper_cond_in) |=> oper_evt_q == '0)
        else $error("operation event not cleared");
    a_ques_clear: assert property (
        clk_en && ques_evt_rd && ques_cond_in == $past(ques_cond_in)
        |=> ques_evt_q == '0) else $error("questionable event not cleared");
    // Preset clears both masks but may never drop an operation event bit
    a_preset_masks: assert property (
        clk_en && stat_preset && !oper_evt_rd |=> oper_ena_rd == '0
        && ques_ena_rd == '0 && (oper_evt_q & $past(oper_evt_q)) ==
        $past(oper_evt_q)) else $error("preset result wrong");
    a_oper_mask: assert property (
        clk_en && oper_ena_wr && !stat_preset |=> oper_ena_rd ==
        $past(ena_wdata)) else $error("operation mask readback wrong");
    a_ques_mask: assert property (
        clk_en && ques_ena_wr && !stat_preset |=> ques_ena_rd ==
        $past(ena_wdata)) else $error("questionable mask readback wrong");
    // Trigger lines pulse for one cycle with the enabled set
    a_ttl_pulse: assert property (
        ttl_oe != '0 |-> ttl_out == ttl_oe && ttl_oe == ttl_ena_rd
        ##1 ttl_oe == '0) else $error("trigger line pulse wrong");
endmodule // dtc_checker
bind dtc_top dtc_checker #(.NTTL(NTTL), .SW(SW)) dtc_checker_inst (
    .clk_sys, .sys_rst, .clk_en, .oper_cond_in, .ques_cond_in,
    .oper_evt_rd, .ques_evt_rd, .oper_ena_wr, .ques_ena_wr, .ena_wdata,
    .stat_preset, .oper_evt_q, .ques_evt_q, .oper_ena_rd, .ques_ena_rd,
    .status_byte, .ttl_ena_rd, .ttl_out, .ttl_oe);

// ===== verification/dtc_cond_model.sv
// Host-side model holding the condition levels of both status groups
`timescale 1ns/1ps
module dtc_cond_model (
    input  wire        clk_sys,
    input  wire        load,
    input  wire [15:0] set_val,
    output logic [15:0] oper_cond_in = 16'h0000,
    output logic [15:0] ques_cond_in = 16'h0000
);
    // Levels move just after an edge, so rises are never ambiguous
    always @(posedge clk_sys) begin
        if (load) begin
            oper_cond_in <= set_val;
            ques_cond_in <= set_val;
        end
    end
endmodule // dtc_cond_model

// ===== verification/test_dtc_top.sv
// Self-checking bench for the D/A trigger, status and channel block
`timescale 1ns/1ps
`include "dtc_consts.vh"
module test_dtc_top;
    logic clk_sys = 0, sys_rst = 1, clk_en = 1, ld = 0, imm_wr = 0;
    logic trg_wr = 0, relay_wr = 0, relay_val = 0, mode_wr = 0, mode_val = 0;
    logic src_wr = 0, soft_trg = 0, common_trg = 0, ext_trg_pin = 0;
    logic abort_cmd = 0, init_cmd = 0, ttl_ena_wr = 0, oper_ena_wr = 0;
    logic ques_ena_wr = 0, stat_preset = 0, oper_evt_rd = 0, tst_all = 0;
    logic ques_evt_rd = 0, tst_start = 0, relay_rd, mode_rd, tst_done;
    logic [3:0] ch_sel = 0, tst_num = 0;
    logic [2:0] src_sel = 0, src_rd;
    logic [7:0] ttl_in_pin = 0, ttl_ena_wdata = 0, ttl_ena_rd, ttl_out;
    logic [7:0] ttl_oe, status_byte;
    logic [15:0] lvl_data = 0, ena_wdata = 0, d, e, m, p = 0, trg_lvl_rd;
    logic [15:0] trg_status, tst_result, relay_out, mode_out, oper_cond_in;
    logic [15:0] ques_cond_in, oper_cond_rd, ques_cond_rd, oper_evt_q;
    logic [15:0] ques_evt_q, oper_ena_rd, ques_ena_rd;
    logic [255:0] dac_out;
    int failures = 0, n_tests = 0, w;
    // Block under test and the condition source beside it
    dtc_top dtc_top_inst (.clk_sys, .sys_rst, .clk_en, .ch_sel, .imm_wr,
        .trg_wr, .lvl_data, .relay_wr, .relay_val, .mode_wr, .mode_val,
        .trg_lvl_rd, .relay_rd, .mode_rd, .dac_out, .relay_out, .mode_out,
        .src_sel, .src_wr, .src_rd, .soft_trg, .common_trg, .ext_trg_pin,
        .ttl_in_pin, .abort_cmd, .init_cmd, .ttl_ena_wdata, .ttl_ena_wr,
        .ttl_ena_rd, .ttl_out, .ttl_oe, .trg_status, .oper_cond_in,
        .ques_cond_in, .oper_ena_wr, .ques_ena_wr, .ena_wdata, .stat_preset,
        .oper_evt_rd, .ques_evt_rd, .oper_cond_rd, .ques_cond_rd,
        .oper_evt_q, .ques_evt_q, .oper_ena_rd, .ques_ena_rd, .status_byte,
        .tst_start, .tst_all, .tst_num, .tst_done, .tst_result);
    dtc_cond_model dtc_cond_model_inst (.clk_sys, .load(ld), .set_val(p),
        .oper_cond_in, .ques_cond_in);
    initial forever #2 clk_sys = ~clk_sys;
    // Inputs change at falling edges, clear of the sampling edge
    task automatic tk(input int n = 1);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pl(ref logic s);
        s = 1;
        tk();
        s = 0;
    endtask
    task automatic chk(input string n, input logic [15:0] x, g);
        n_tests++;
        if (g !== x) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    // Soft trigger counts for bus and hold; immediate fires by itself
    function automatic bit applies(input int s);
        return s == `DTC_SRC_BUS || s == `DTC_SRC_HOLD || s == `DTC_SRC_IMM;
    endfunction
    function automatic logic [7:0] stb(input logic [15:0] oe, om, qe, qm);
        return {|(oe & om), 3'h0, |(qe & qm), 3'h0};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: reset, channels, trigger, status, self-test
    initial begin
        void'($urandom(32'hA706));
        tk(4);
        sys_rst = 0;
        tk();
        chk("src_rd", `DTC_SRC_RST, src_rd);
        chk("trg_status", {10'h000, 1'b0, `DTC_SRC_RST, `DTC_ST_IDLE}, trg_status);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            ch_sel = $urandom;
            lvl_data = $urandom;
            relay_val = $urandom;
            mode_val = $urandom;
            pl(imm_wr);
            pl(relay_wr);
            pl(mode_wr);
            tk();
            chk("trg_lvl_rd", lvl_data, trg_lvl_rd);
            chk("dac_out", lvl_data, dac_out[ch_sel*16 +: 16]);
            chk("relay_rd", relay_val, relay_rd);
            chk("mode_rd", mode_val, mode_rd);
            chk("relay_out", relay_val, relay_out[ch_sel]);
            chk("mode_out", mode_val, mode_out[ch_sel]);
        end
        // Frozen clock enable must drop a write entirely
        clk_en = 0;
        lvl_data = ~lvl_data;
        pl(imm_wr);
        clk_en = 1;
        tk();
        chk("dac_out", ~lvl_data, dac_out[ch_sel*16 +: 16]);
        chk("trg_lvl_rd", ~lvl_data, trg_lvl_rd);
        $display("test channels done");
        ttl_ena_wdata = $urandom | 8'h01;
        pl(ttl_ena_wr);
        // Every source code, pending value loaded before arming
        for (int s = 0; s < 5; s++) begin
            ch_sel = $urandom;
            d = $urandom;
            src_sel = s;
            relay_val = 1;
            lvl_data = ~d;
            pl(src_wr);
            pl(relay_wr);
            pl(imm_wr);
            lvl_data = d;
            pl(trg_wr);
            chk("dac_out", ~d, dac_out[ch_sel*16 +: 16]);
            pl(init_cmd);
            chk("trg_lvl_rd", d, trg_lvl_rd);
            pl(soft_trg);
            chk("dac_out", applies(s) ? d : ~d, dac_out[ch_sel*16 +: 16]);
            chk("ttl_out", applies(s) ? ttl_ena_wdata : 8'h00, ttl_out);
            tk();
            e = {10'h0, !applies(s), src_sel, applies(s) ? 2'h1 : 2'h2};
            chk("trg_status", e, trg_status);
            chk("src_rd", src_sel, src_rd);
            if (s == 2 || s == 3) begin
                // Pin rise fires after two sync stages; outputs register on the third edge
                ext_trg_pin = (s == 2);
                ttl_in_pin = (s == 3) ? ($urandom | 8'h01) : 8'h00;
                tk(3);
                chk("dac_out", d, dac_out[ch_sel*16 +: 16]);
                chk("ttl_out", ttl_ena_wdata, ttl_out);
                ext_trg_pin = 0;
                ttl_in_pin = 0;
            end
            pl(abort_cmd);
            lvl_data = ~d;
            pl(trg_wr);
            chk("trg_state", `DTC_ST_IDLE, trg_status[1:0]);
            pl(init_cmd);
            pl(common_trg);
            chk("dac_out", ~d, dac_out[ch_sel*16 +: 16]);
        end
        chk("ttl_ena_rd", ttl_ena_wdata, ttl_ena_rd);
        // Open relay keeps the pending value off the output
        relay_val = 0;
        pl(relay_wr);
        lvl_data = d;
        pl(trg_wr);
        pl(init_cmd);
        pl(common_trg);
        chk("dac_out", ~d, dac_out[ch_sel*16 +: 16]);
        pl(abort_cmd);
        $display("test trigger done");
        m = $urandom | 16'h0001;
        p = $urandom | 16'h0001;
        ena_wdata = m;
        pl(oper_ena_wr);
        pl(ques_ena_wr);
        pl(ld);
        tk(2);
        chk("oper_ena_rd", m, oper_ena_rd);
        chk("status_byte", stb(p, m, p, m), status_byte);
        pl(oper_evt_rd);
        chk("oper_evt_q", 16'h0000, oper_evt_q);
        chk("oper_cond_rd", p, oper_cond_rd);
        pl(stat_preset);
        tk();
        chk("ques_ena_rd", 16'h0000, ques_ena_rd);
        chk("status_byte", 8'h00, status_byte);
        chk("ques_evt_q", p, ques_evt_q);
        pl(ques_evt_rd);
        chk("ques_evt_q", 16'h0000, ques_evt_q);
        chk("ques_cond_rd", p, ques_cond_rd);
        $display("test status done");
        for (int k = 0; k < 2; k++) begin
            tst_all = k;
            tst_num = $urandom_range(3);
            pl(tst_start);
            for (w = 0; w < 20 && tst_done !== 1'b1; w++)
                tk();
            if (w == 20) begin
                failures++;
                $display("unexpected tst_done: expected 1 seen 0");
            end else
                chk("tst_result", `DTC_TST_PASS, tst_result);
        end
        $display("test self-test done");
        print_verdict();
    end
endmodule // test_dtc_top
